// File: rtl/hs_timer.sv
// High-speed timer: prescaler, 32-bit counter, three matches, two captures.
`include "hs_timer_defines.svh"
// Overview of operation
// - Prescaler period advances the 32-bit counter.
// - Three match values compared, optional interrupt.
// - Match continues, stops or zeroes counter.
// - Two captures snapshot counter on input edge.
// - Capture event optionally raises interrupt.
// - Debug pause freezes prescaler and counter.
module hs_timer
	import hs_timer_pkg::*;
(
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire logic                              count_enable,
	input  wire logic                              count_clear,
	input  wire logic [`PRESCALE_W-1:0]            prescale_limit,
	input  wire logic                              debug_halt,
	input  wire logic                              pause_on_debug,
	input  wire logic [`NUM_MATCH*`COUNT_W-1:0]    match_value,
	input  wire logic [`NUM_MATCH*2-1:0]           match_action,
	input  wire logic [`NUM_MATCH-1:0]             match_irq_en,
	input  wire logic [`NUM_CAPTURE-1:0]           capture_pin,
	input  wire logic [`NUM_CAPTURE-1:0]           capture_rise_en,
	input  wire logic [`NUM_CAPTURE-1:0]           capture_fall_en,
	input  wire logic [`NUM_CAPTURE-1:0]           capture_irq_en,
	input  wire logic [`NUM_MATCH-1:0]             match_flag_clear,
	input  wire logic [`NUM_CAPTURE-1:0]           capture_flag_clear,
	output logic      [`COUNT_W-1:0]               count,
	output logic      [`NUM_CAPTURE*`COUNT_W-1:0]  capture_value,
	output logic      [`NUM_MATCH-1:0]             match_flag,
	output logic      [`NUM_CAPTURE-1:0]           capture_flag,
	output logic                                   irq
);
	logic [`PRESCALE_W-1:0]  pre_r;
	logic [`PRESCALE_W-1:0]  pre_nxt;
	logic [`COUNT_W-1:0]     cnt_r;
	logic [`COUNT_W-1:0]     cnt_nxt;
	logic                    run_r;
	logic                    run_nxt;
	logic [`NUM_MATCH-1:0]   mflag_r;
	logic [`NUM_MATCH-1:0]   mflag_nxt;
	logic [`NUM_CAPTURE-1:0] cflag_r;
	logic [`NUM_CAPTURE-1:0] cflag_nxt;
	logic [`NUM_MATCH-1:0]   hit;
	logic [`NUM_MATCH-1:0]   hit_d_r;
	logic [`NUM_CAPTURE-1:0] cap_evt;
	logic                    frozen;
	logic                    tick;
	logic                    do_stop;
	logic                    do_zero;
	match_action_t           act [`NUM_MATCH];
	logic [`NUM_MATCH-1:0]   hit_d_nxt;
	logic [`NUM_MATCH-1:0]   done_r;
	logic [`NUM_MATCH-1:0]   done_nxt;
	logic [`NUM_MATCH-1:0]   arrive;
	logic [`NUM_MATCH-1:0]   take;
	logic [`NUM_MATCH-1:0]   want_stop;
	logic [`NUM_MATCH-1:0]   want_zero;
	logic                    may_zero;
	logic                    pre_wrap;
	logic [`PRESCALE_W-1:0]  pre_inc;
	logic [`COUNT_W-1:0]     cnt_inc;
	logic [`NUM_MATCH-1:0]   match_irq;
	logic [`NUM_CAPTURE-1:0] cap_irq;

	capture_if cap_ch [`NUM_CAPTURE] ();

	genvar g;
	generate
		for (g = 0; g < `NUM_CAPTURE; g++) begin : g_cap
			assign cap_ch[g].pin_in = capture_pin[g];
			assign cap_ch[g].count  = cnt_r;
			assign cap_evt[g]       = cap_ch[g].event_pulse;
			assign capture_value[g*`COUNT_W +: `COUNT_W] = cap_ch[g].value;
			capture_unit u_cap (
				.clk     (clk),
				.rst_n   (rst_n),
				.rise_en (capture_rise_en[g]),
				.fall_en (capture_fall_en[g]),
				.cap     (cap_ch[g])
			);
		end
		for (g = 0; g < `NUM_MATCH; g++) begin : g_match
			assign hit[g] = (cnt_r == match_value[g*`COUNT_W +: `COUNT_W]);
			assign act[g] = match_action_t'(match_action[g*2 +: 2]);
		end
	endgenerate

	// Match bookkeeping.
	// Arrive marks the first cycle of equality and raises the flag.
	// Done records that the action of the present arrival was carried out, so a stopped
	// counter can be restarted past its match value.
	always_comb begin
		hit_d_nxt = hit;
		may_zero  = run_r & ~frozen & ~count_clear;
		for (int i = 0; i < `NUM_MATCH; i++) begin
			arrive[i]    = hit[i] & ~hit_d_r[i];
			want_stop[i] = (act[i] == MATCH_STOP);
			want_zero[i] = (act[i] == MATCH_RESET);
			// A zeroing match seen while frozen waits for counting to resume, so it is not lost.
			take[i]      = hit[i] & ~done_r[i] & (~want_zero[i] | may_zero);
			done_nxt[i]  = hit[i] & (done_r[i] | take[i]);
		end
		do_stop = |(take & want_stop);
		do_zero = |(take & want_zero);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_d_r <= 3'h0;
			done_r  <= 3'h0;
		end else begin
			hit_d_r <= hit_d_nxt;
			done_r  <= done_nxt;
		end
	end

	// Run state: set by an enable, cleared by a stopping match, which wins.
	always_comb begin
		run_nxt = run_r;
		if (count_enable) begin
			run_nxt = 1'b1;
		end
		if (do_stop) begin
			run_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
		end
	end

	// Counter and prescaler; a clear outranks both the pause and the match actions.
	always_comb begin
		frozen   = pause_on_debug & debug_halt;
		pre_wrap = (pre_r >= prescale_limit);
		pre_inc  = pre_r + 16'h0001;
		cnt_inc  = cnt_r + 32'h0000_0001;
		tick     = 1'b0;
		pre_nxt  = pre_r;
		cnt_nxt  = cnt_r;
		if (count_clear) begin
			pre_nxt = `PRESCALE_RST;
			cnt_nxt = `COUNT_RESET;
		end else if (run_r && !frozen) begin
			if (pre_wrap) begin
				pre_nxt = `PRESCALE_RST;
				tick    = 1'b1;
			end else begin
				pre_nxt = pre_inc;
			end
			if (do_zero) begin
				cnt_nxt = `COUNT_RESET;
				pre_nxt = `PRESCALE_RST;
			end else if (tick && !do_stop) begin
				cnt_nxt = cnt_inc;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= `PRESCALE_RST;
			cnt_r <= `COUNT_RESET;
		end else begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Sticky flags; a new event beats a clear in the same cycle.
	always_comb begin
		mflag_nxt = (mflag_r & ~match_flag_clear) | arrive;
		cflag_nxt = (cflag_r & ~capture_flag_clear) | cap_evt;
		match_irq = mflag_r & match_irq_en;
		cap_irq   = cflag_r & capture_irq_en;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mflag_r <= 3'h0;
			cflag_r <= 2'h0;
		end else begin
			mflag_r <= mflag_nxt;
			cflag_r <= cflag_nxt;
		end
	end

	assign count        = cnt_r;
	assign match_flag   = mflag_r;
	assign capture_flag = cflag_r;
	assign irq          = |match_irq | |cap_irq;
endmodule : hs_timer

// File: pkg/hs_timer_defines.svh
// Constants for the high-speed capture and match timer.
`ifndef HS_TIMER_DEFINES_SVH
`define HS_TIMER_DEFINES_SVH
`define PRESCALE_W   16
`define COUNT_W      32
`define NUM_MATCH    3
`define NUM_CAPTURE  2
`define COUNT_RESET  32'h0000_0000
`define PRESCALE_RST 16'h0000
`endif

// File: pkg/hs_timer_pkg.sv
// Types shared by the high-speed capture and match timer.
package hs_timer_pkg;
	typedef enum logic [1:0] {
		MATCH_CONTINUE = 2'h0,
		MATCH_STOP     = 2'h1,
		MATCH_RESET    = 2'h2
	} match_action_t;
endpackage : hs_timer_pkg

// File: pkg/capture_if.sv
// Carries one capture channel between the timer core and its capture unit.
`include "hs_timer_defines.svh"
interface capture_if;
	logic                  pin_in;
	logic [`COUNT_W-1:0]   count;
	logic                  event_pulse;
	logic [`COUNT_W-1:0]   value;
	modport core (output pin_in, output count, input event_pulse, input value);
	modport unit (input pin_in, input count, output event_pulse, output value);
endinterface : capture_if

// File: rtl/capture_unit.sv
// One capture channel: pin synchroniser, edge detect and snapshot register.
`include "hs_timer_defines.svh"
module capture_unit (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic rise_en,
	input  wire logic fall_en,
	capture_if.unit   cap
);
	logic [2:0]            sync_r;
	logic [2:0]            sync_nxt;
	logic                  level_r;
	logic                  level_nxt;
	logic [`COUNT_W-1:0]   value_r;
	logic [`COUNT_W-1:0]   value_nxt;
	logic                  pulse;

	// Third stage must agree with the second before a change is accepted.
	always_comb begin
		sync_nxt  = {sync_r[1:0], cap.pin_in};
		level_nxt = level_r;
		if (sync_r[1] == sync_r[2]) begin
			level_nxt = sync_r[2];
		end
		pulse     = (level_nxt & ~level_r & rise_en) | (~level_nxt & level_r & fall_en);
		value_nxt = pulse ? cap.count : value_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_r  <= 3'h0;
			level_r <= 1'b0;
			value_r <= `COUNT_RESET;
		end else begin
			sync_r  <= sync_nxt;
			level_r <= level_nxt;
			value_r <= value_nxt;
		end
	end

	assign cap.event_pulse = pulse;
	assign cap.value       = value_r;
endmodule : capture_unit

// File: tb/hs_timer_properties.sv
// Port-level checks for the high-speed timer.
module hs_timer_properties (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        count_clear,
	input wire logic        debug_halt,
	input wire logic        pause_on_debug,
	input wire logic [95:0] match_value,
	input wire logic [5:0]  match_action,
	input wire logic [2:0]  match_irq_en,
	input wire logic [1:0]  capture_irq_en,
	input wire logic [2:0]  match_flag_clear,
	input wire logic [31:0] count,
	input wire logic [63:0] capture_value,
	input wire logic [2:0]  match_flag,
	input wire logic [1:0]  capture_flag,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire       hit = count == match_value[31:0];
	wire       nc = !count_clear;
	wire [1:0] act0 = match_action[1:0];
	// A clear outranks the pause, so the freeze is only claimed without one.
	wire       frz = pause_on_debug && debug_halt && nc;
	a_count_step: assert property ($changed(count) |-> count == $past(count) + 1 || !count)
		else $error("count step");
	a_match_flag: assert property ($rose(hit) |=> match_flag[0])
		else $error("no match flag");
	a_match_stop: assert property ($rose(hit) && nc && act0 == 2'h1 |=> $stable(count))
		else $error("no stop");
	a_match_zero: assert property ($rose(hit) && nc && !(pause_on_debug && debug_halt) && act0 == 2'h2 |=> !count)
		else $error("no zero");
	a_capture_flag: assert property ($changed(capture_value[31:0]) |-> capture_flag[0])
		else $error("no capture flag");
	a_irq_level: assert property (irq == |{match_flag & match_irq_en, capture_flag & capture_irq_en})
		else $error("irq wrong");
	a_debug_freeze: assert property (frz |=> $stable(count))
		else $error("not frozen");
	a_flag_hold: assert property (match_flag[0] && !match_flag_clear[0] |=> match_flag[0])
		else $error("flag lost");
	c_zero: cover property ($rose(hit) && act0 == 2'h2);
	c_capture: cover property ($rose(capture_flag[0]));
	c_freeze: cover property (frz);
endmodule : hs_timer_properties

// File: tb/capture_src.sv
// Outside source toggling the two capture inputs.
module capture_src (
	input  wire logic       clk,
	input  wire logic [1:0] flip,
	output logic      [1:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin = 2'h0;
	// Changes land on the falling edge, away from the synchroniser's sampling edge.
	always @(negedge clk) pin <= pin ^ flip;
endmodule : capture_src

// File: tb/testbench.sv
// Random stimulus checked against a cycle model of the timer.
module testbench
	import hs_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, irq, count_enable, count_clear, debug_halt;
	logic        pause_on_debug;
	logic [15:0] prescale_limit;
	logic [95:0] match_value;
	logic [5:0]  match_action;
	logic [2:0]  match_irq_en, match_flag_clear, match_flag;
	logic [1:0]  capture_pin, capture_rise_en, capture_fall_en, capture_irq_en, flip;
	logic [1:0]  capture_flag_clear, capture_flag;
	logic [31:0] count, s = 32'hd21a3678, r;
	logic [63:0] capture_value;
	int          err_count = 0, check_count = 0, cnt_m = 0, pre_m = 0, run_m = 0;
	logic [2:0]  mf_m = 3'h0, hd_m = 3'h0, hit_m;
	logic [1:0]  cf_m = 2'h0, lv_m = 2'h0, s0_m = 2'h0, s1_m = 2'h0, s2_m = 2'h0, pl_m;
	logic [63:0] cv_m = 64'h0;
	logic        nl;
	hs_timer dut (.*);
	capture_src src (.clk, .flip, .pin(capture_pin));
	always #5 clk = ~clk;
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim
	// Model of the count; it is only trusted while every match continues.
	// Flags and captures are read from the count before this edge updates it.
	always @(posedge clk) begin
		if (rst_n) begin
			for (int k = 0; k < 3; k++) hit_m[k] = cnt_m == match_value[32*k +: 32];
			mf_m = (mf_m & ~match_flag_clear) | (hit_m & ~hd_m);
			hd_m = hit_m;
			for (int k = 0; k < 2; k++) begin
				// A pin change counts once the second and third stages agree.
				nl = (s1_m[k] == s2_m[k]) ? s2_m[k] : lv_m[k];
				pl_m[k] = (nl & !lv_m[k] & capture_rise_en[k]) | (!nl & lv_m[k] & capture_fall_en[k]);
				lv_m[k] = nl;
				if (pl_m[k]) cv_m[32*k +: 32] = 32'(cnt_m);
			end
			cf_m = (cf_m & ~capture_flag_clear) | pl_m;
			s2_m = s1_m;
			s1_m = s0_m;
			s0_m = capture_pin;
			if (count_clear) begin
				pre_m = 0;
				cnt_m = 0;
			end else if (run_m != 0 && !(pause_on_debug && debug_halt)) begin
				if (pre_m == prescale_limit) cnt_m++;
				pre_m = (pre_m == prescale_limit) ? 0 : pre_m + 1;
			end
			if (count_enable) run_m = 1;
		end
	end
	initial begin
		{count_enable, count_clear, debug_halt, pause_on_debug, flip} = '0;
		{match_action, match_flag_clear, capture_flag_clear} = '0;
		r = xs();
		prescale_limit = 16'(r[1:0]);
		{match_irq_en, capture_irq_en, capture_rise_en, capture_fall_en} = r[10:2];
		match_value = {xs() & 32'h3f, xs() & 32'h3f, xs() & 32'h3f};
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (i < 2000) begin
				check(count, cnt_m);
				check(32'(match_flag), 32'(mf_m));
				check(capture_value[31:0], cv_m[31:0]);
				check(capture_value[63:32], cv_m[63:32]);
				check(32'(capture_flag), 32'(cf_m));
				check(32'(irq), 32'(|(mf_m & match_irq_en) | |(cf_m & capture_irq_en)));
			end else begin
				check(32'(count <= 32'h6), 32'h1);
			end
			r = xs();
			// Without restarts a stopped count stays put, so the bound holds for both actions.
			count_enable = r[31] & (i < 2500);
			count_clear = i == 1999 || r[7:0] == 8'h0;
			{debug_halt, pause_on_debug} = r[9:8];
			flip = r[12:11] & {2{r[13]}};
			match_flag_clear = r[16:14] & {3{r[17]}};
			capture_flag_clear = r[19:18] & {2{r[20]}};
			if (i >= 1999) begin
				match_value[31:0] = 32'h6;
				match_action[1:0] = (i < 2500) ? MATCH_RESET : MATCH_STOP;
			end
		end
		end_sim();
	end
endmodule : testbench
bind hs_timer hs_timer_properties chk (.*);
